// File: logic/npwp_buf_mem.v
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Write buffer storage with registered read data.
// ---------------------------------------------------------------
module npwp_buf_mem #(
	parameter WIDTH = 16,
	parameter AW    = 3
) (
	input  wire             ref_clk,
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_addr,
	input  wire [WIDTH-1:0] wr_data,
	input  wire [AW-1:0]    rd_addr,
	output reg  [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:(1<<AW)-1];

	always @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// File: logic/npwp_defs.vh
`ifndef NPWP_DEFS_VH
`define NPWP_DEFS_VH

// ---------------------------------------------------------------
// Stall limit, buffer sizing and flash timing.
// ---------------------------------------------------------------
`define NPWP_STALL_LIMIT     9'h100
`define NPWP_BUF_DEPTH       8
`define NPWP_BUF_AW          3
`define NPWP_FLASH_WR_NS     100
`define NPWP_CLK_NS          50
`define NPWP_FLASH_WR_CYC    ((`NPWP_FLASH_WR_NS + `NPWP_CLK_NS - 1) / `NPWP_CLK_NS)

// ---------------------------------------------------------------
// Port kinds.
// ---------------------------------------------------------------
`define NPWP_KIND_CMD        2'h0
`define NPWP_KIND_ADDR       2'h1
`define NPWP_KIND_DATA       2'h2

`endif

// File: logic/npwp_path.v
`timescale 1ns/10ps
`include "npwp_defs.vh"

// Function
// - With forcing set, more than 256 unbroken port writes without drain stall the path.
// - The empty flag reads 0 while writes are pending and 1 once fully drained.
// - The run of writes is counted over all chip selects together.
// - Writes from the posting engine never take part in the stall.
module npwp_path #(
	parameter DATA_W  = 16,
	parameter CS_W    = 3,
	parameter AW      = `NPWP_BUF_AW,
	parameter WR_CYC  = `NPWP_FLASH_WR_CYC
) (
	input  wire              ref_clk,
	input  wire              sys_rst,
	input  wire              flash_posted_write_force,
	input  wire              host_wr,
	input  wire              host_from_engine,
	input  wire [1:0]        host_kind,
	input  wire [CS_W-1:0]   host_cs,
	input  wire [DATA_W-1:0] host_wdata,
	output reg               host_ready,
	output reg               write_buffer_empty_flag,
	output reg               stalled,
	output reg               flash_we,
	output reg  [1:0]        flash_kind,
	output reg  [CS_W-1:0]   flash_cs,
	output reg  [DATA_W-1:0] flash_data
);
	localparam EW = DATA_W + CS_W + 3;
	localparam DEPTH = 1 << AW;
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_READ = 2'h1;
	localparam [1:0] ST_WRITE = 2'h2;

	// ---------------------------------------------------------------
	// Buffer pointers and occupancy.
	// ---------------------------------------------------------------
	reg  [AW:0]     wp_reg;
	reg  [AW:0]     rp_reg;
	reg  [8:0]      run_reg;
	reg  [1:0]      st_reg;
	reg  [15:0]     tmr_reg;
	wire [AW:0]     used;
	wire            full;
	wire            empty;
	wire            accept;
	wire            direct;
	wire            pop;
	wire            run_next_stall;
	wire            run_at_limit;
	wire [EW-1:0]   rd_entry;

	assign used  = wp_reg - rp_reg;
	assign full  = (used == DEPTH[AW:0]);
	assign empty = (used == {(AW+1){1'b0}});
	// Engine writes and unforced writes bypass run counting.
	assign direct = host_from_engine | ~flash_posted_write_force;
	assign accept = host_wr & host_ready;
	assign pop = (st_reg == ST_IDLE) & ~empty;
	// The next counted write stalls once the unbroken run reaches the limit.
	assign run_next_stall = (run_reg >= `NPWP_STALL_LIMIT);
	// Ready drops once the run reaches the limit, so the next one is refused.
	assign run_at_limit = run_next_stall | (accept & ~direct &
		(run_reg == (`NPWP_STALL_LIMIT - 9'h001)));

	npwp_buf_mem #(
		.WIDTH (EW),
		.AW    (AW)
	) u_mem (
		.ref_clk (ref_clk),
		.wr_en   (accept),
		.wr_addr (wp_reg[AW-1:0]),
		.wr_data ({direct, host_kind, host_cs, host_wdata}),
		.rd_addr (rp_reg[AW-1:0]),
		.rd_data (rd_entry)
	);

	// ---------------------------------------------------------------
	// Host side: accept writes and count the run.
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			wp_reg     <= {(AW+1){1'b0}};
			run_reg    <= 9'h000;
			host_ready <= 1'b0;
			stalled    <= 1'b0;
		end else begin
			if (accept) begin
				wp_reg <= wp_reg + 1'b1;
			end
			// A drained buffer ends the run, unless a write lands now.
			if (empty & ~accept & (st_reg == ST_IDLE)) begin
				run_reg <= 9'h000;
				stalled <= 1'b0;
			end else if (accept & ~direct & ~run_next_stall) begin
				// All chip selects share one counter.
				run_reg <= run_reg + 9'h001;
			end else if (host_wr & ~direct & run_next_stall) begin
				stalled <= 1'b1;
			end
			host_ready <= ~stalled & ~run_at_limit &
				(used + {{AW{1'b0}}, accept} < DEPTH[AW:0]);
		end
	end

	// ---------------------------------------------------------------
	// Flash side: drain one entry per write cycle.
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			rp_reg     <= {(AW+1){1'b0}};
			st_reg     <= ST_IDLE;
			tmr_reg    <= 16'h0000;
			flash_we   <= 1'b0;
			flash_kind <= `NPWP_KIND_CMD;
			flash_cs   <= {CS_W{1'b0}};
			flash_data <= {DATA_W{1'b0}};
		end else begin
			case (st_reg)
			ST_IDLE: begin
				flash_we <= 1'b0;
				if (pop & ~(stalled & ~full)) begin
					st_reg <= ST_READ;
				end
			end
			ST_READ: begin
				flash_we   <= 1'b1;
				flash_kind <= rd_entry[DATA_W+CS_W+1:DATA_W+CS_W];
				flash_cs   <= rd_entry[DATA_W+CS_W-1:DATA_W];
				flash_data <= rd_entry[DATA_W-1:0];
				tmr_reg    <= WR_CYC[15:0];
				st_reg     <= ST_WRITE;
			end
			ST_WRITE: begin
				if (tmr_reg <= 16'h0001) begin
					flash_we <= 1'b0;
					rp_reg   <= rp_reg + 1'b1;
					st_reg   <= ST_IDLE;
				end else begin
					tmr_reg <= tmr_reg - 16'h0001;
				end
			end
			default: begin
				st_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Status flag.
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			write_buffer_empty_flag <= 1'b1;
		end else begin
			// Reads 1 only when nothing is queued or in flight.
			write_buffer_empty_flag <= empty & ~accept & (st_reg == ST_IDLE) &
				~pop;
		end
	end
endmodule

// File: tb/npwp_flash_model.sv
`timescale 1ns/10ps
module npwp_flash_model (
	input wire        ref_clk,
	input wire        flash_we,
	input wire [1:0]  flash_kind,
	input wire [2:0]  flash_cs,
	input wire [15:0] flash_data,
	output reg [20:0] last_write
);
	reg we_d = 1'b0;
	// Latches each flash write as its strobe rises.
	always @(posedge ref_clk) begin
		we_d <= flash_we;
		if (flash_we && !we_d)
			last_write <= {flash_kind, flash_cs, flash_data};
	end
endmodule

// File: tb/npwp_path_checker.sv
`timescale 1ns/10ps
module npwp_path_checker (
	input wire ref_clk,
	input wire sys_rst,
	input wire flash_posted_write_force,
	input wire host_wr,
	input wire host_from_engine,
	input wire host_ready,
	input wire write_buffer_empty_flag,
	input wire stalled,
	input wire flash_we
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence take_s;
		host_wr && host_ready;
	endsequence
	stall_refuse_a: assert property (stalled |-> !host_ready)
		else $error("ready while stalled");
	stall_hold_a: assert property (stalled |=> stalled)
		else $error("stall released");
	take_empty_a: assert property (take_s |=> !write_buffer_empty_flag)
		else $error("empty after take");
	idle_empty_a: assert property (write_buffer_empty_flag |-> !flash_we)
		else $error("empty while writing");
	stall_cause_a: assert property ($rose(stalled) |->
		$past(flash_posted_write_force && host_wr && !host_from_engine))
		else $error("stall without counted write");
endmodule

bind npwp_path npwp_path_checker u_npwp_path_checker (.ref_clk, .sys_rst,
	.flash_posted_write_force, .host_wr, .host_from_engine, .host_ready,
	.write_buffer_empty_flag, .stalled, .flash_we);

// File: tb/npwp_path_tb_top.sv
`timescale 1ns/10ps
module npwp_path_tb_top;
	reg        ref_clk = 1'b0;
	reg        sys_rst = 1'b1;
	reg        flash_posted_write_force = 1'b0;
	reg        host_wr = 1'b0;
	reg        host_from_engine = 1'b0;
	reg [1:0]  host_kind = 2'h0;
	reg [2:0]  host_cs = 3'h0;
	reg [15:0] host_wdata = 16'h0000;
	wire       host_ready, write_buffer_empty_flag, stalled, flash_we;
	wire [1:0] flash_kind;
	wire [2:0] flash_cs;
	wire [15:0] flash_data;
	wire [20:0] last_write;
	int        fails = 0;
	int        compares = 0;
	reg        ok;
	reg [20:0] rows [0:2] = '{{2'h0, 3'h1, 16'h00A5},
		{2'h1, 3'h4, 16'h5A5A}, {2'h2, 3'h7, 16'hFFFF}};
	npwp_path u_npwp_path (.ref_clk, .sys_rst, .flash_posted_write_force,
		.host_wr, .host_from_engine, .host_kind, .host_cs, .host_wdata,
		.host_ready, .write_buffer_empty_flag, .stalled, .flash_we,
		.flash_kind, .flash_cs, .flash_data);
	npwp_flash_model u_npwp_flash_model (.ref_clk, .flash_we, .flash_kind,
		.flash_cs, .flash_data, .last_write);
	always #25 ref_clk = ~ref_clk;
	task check(input bit c, input string m);
		compares++;
		if (!c) begin
			fails++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task give_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wr(input [20:0] v, input bit e);
		@(negedge ref_clk);
		{host_kind, host_cs, host_wdata} = v;
		host_from_engine = e;
		host_wr = 1'b1;
		ok = 1'b0;
		for (int n = 0; n < 40 && !ok; n++) begin
			ok = (host_ready === 1'b1);
			@(negedge ref_clk);
		end
		host_wr = 1'b0;
	endtask
	task run(input int cnt, input bit e, input [20:0] v);
		for (int i = 0; i < cnt; i++) begin
			wr(v ^ 21'(i), e);
			check(ok, "write refused");
		end
	endtask
	task wait_empty;
		for (int n = 0; n < 99 && write_buffer_empty_flag !== 1'b1; n++)
			@(negedge ref_clk);
		check(write_buffer_empty_flag === 1'b1, "no drain");
	endtask
	initial begin
		repeat (20) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge ref_clk);
		check(write_buffer_empty_flag === 1'b1 && stalled === 1'b0, "rst");
		for (int i = 0; i < 3; i++) begin
			wr(rows[i], 1'b0);
			wait_empty;
			check(last_write === rows[i], "flash write");
		end
		flash_posted_write_force = 1'b1;
		run(255, 1'b0, rows[2]);
		wait_empty;
		run(255, 1'b0, rows[1]);
		run(300, 1'b1, rows[0]);
		check(stalled === 1'b0, "run not cleared");
		wait_empty;
		run(128, 1'b0, rows[2]);
		run(128, 1'b0, rows[1]);
		wr(rows[0], 1'b0);
		check(!ok && stalled === 1'b1, "no stall");
		give_verdict;
	end
endmodule
